// ### dv/ecv_ebox_regs_tb_top.sv
// Purpose: Self-checking bench for the execution-box register block.
// Assumes: Stimulus changes at the falling edge; a reference model
//          updates its state at each rising edge from the same stimulus.
// Notes:   Read answers and memory-pipe results are matched to queued notes.
`default_nettype none

module ecv_ebox_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------
  // Connections and bench state
  // ----------------------------------------
  logic clk;
  logic reset_n;
  ecv_pkg::ecv_ipr_req_s ipr_req;
  ecv_pkg::ecv_fault_s fault;
  ecv_pkg::ecv_mem_s mem;
  logic [63:0] rd_data;
  logic rd_valid;
  logic access_violation;
  logic [2:0] paddr_low_out;
  logic [2:0] shift_amount_out;
  logic wide_address_select;
  logic big_endian_mode;
  int failures;
  int checked;
  logic [31:0] lfsr;
  logic [63:0] v;
  logic [63:0] read_q[$];
  logic [8:0] mem_q[$];
  logic [31:0] m_hi, m_lo;
  logic [63:0] m_va;
  logic [33:0] m_base;
  logic m_en, m_cmp, m_wide, m_be;
  logic [7:0] idx_list[8];
  logic [63:0] va_tab[5];

  ecv_ebox_regs ecv_ebox_regs_inst (
    .clk(clk), .reset_n(reset_n), .ipr_req(ipr_req), .rd_data(rd_data),
    .rd_valid(rd_valid), .fault(fault), .mem(mem), .access_violation(access_violation),
    .paddr_low_out(paddr_low_out), .shift_amount_out(shift_amount_out),
    .wide_address_select(wide_address_select), .big_endian_mode(big_endian_mode)
  );

  // Free-running 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic void rnd64(output logic [63:0] r);
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    r[63:32] = lfsr;
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    r[31:0] = lfsr;
  endfunction

  // Entry view layout; compact select overrides the width select
  function automatic logic [63:0] view_exp();
    if (m_cmp) return {m_base[33:3], 11'h000, m_va[31:13], 3'h0};
    if (m_wide) return {m_base[33:8], m_va[47:13], 3'h0};
    return {m_base[33:3], m_va[42:13], 3'h0};
  endfunction

  // Upper bits must all repeat the sign bit of the chosen format
  function automatic logic sign_extend_bad(input logic [63:0] va, input logic w);
    if (w) return va[63:47] != {17{va[47]}};
    return va[63:42] != {22{va[42]}};
  endfunction

  function automatic logic [2:0] size_mask(input ecv_pkg::ecv_size_e s);
    case (s)
      ecv_pkg::ECV_SIZE_BYTE: return 3'h7;
      ecv_pkg::ECV_SIZE_WORD: return 3'h6;
      ecv_pkg::ECV_SIZE_LONG: return 3'h4;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [63:0] read_exp(input logic [7:0] idx);
    case (idx)
      ecv_pkg::ECV_IDX_CYCLE_COUNT: return {m_hi, m_lo};
      ecv_pkg::ECV_IDX_FAULT_VA: return m_va;
      ecv_pkg::ECV_IDX_PTE_VIEW: return view_exp();
      default: return 64'h0000_0000_0000_0000;
    endcase
  endfunction

  // ----------------------------------------
  // Reference model: notes expectations, then updates state
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {m_hi, m_lo, m_va, m_base, m_en, m_cmp, m_wide, m_be} = '0;
      read_q.delete();
      mem_q.delete();
    end else begin
      if (ipr_req.read_cycle_count_op) read_q.push_back({m_hi, m_lo});
      else if (ipr_req.rd) read_q.push_back(read_exp(ipr_req.index));
      // Mode bits sampled before this edge's write, as the pipe sees them
      if (mem.valid) mem_q.push_back({sign_extend_bad(mem.vaddr, m_wide),
        m_be ? mem.paddr_low ^ size_mask(mem.size) : mem.paddr_low,
        m_be ? ~mem.shift_amount : mem.shift_amount, m_wide, m_be});
      if (ipr_req.wr && ipr_req.index == ecv_pkg::ECV_IDX_CYCLE_COUNT) begin
        m_hi = ipr_req.wdata[63:32];
      end
      if (ipr_req.wr && ipr_req.index == ecv_pkg::ECV_IDX_COUNT_CTL) begin
        m_en = ipr_req.wdata[32];
        m_lo = {ipr_req.wdata[31:4], 4'h0};
      end else if (m_en) begin
        m_lo = m_lo + 32'h0000_0001;
      end
      if (ipr_req.wr && ipr_req.index == ecv_pkg::ECV_IDX_ADDR_CTL) begin
        {m_base, m_cmp, m_wide, m_be} = {ipr_req.wdata[63:30], ipr_req.wdata[2:0]};
      end
      if ((fault.dtb_miss || fault.dstream_fault) && !fault.page_entry_load) begin
        m_va = fault.vaddr;
      end
    end
  end

  // ----------------------------------------
  // Compare tasks and monitor
  // ----------------------------------------
  task automatic cmp_read(input logic [63:0] exp, input logic [63:0] got, input logic vld);
    checked++;
    if (vld !== 1'b1 || got !== exp) begin
      failures++;
      $display("Error at %0t ns: read %h valid %b, expected %h", $time, got, vld, exp);
    end
  endtask

  task automatic cmp_mem(input logic [8:0] exp, input logic [8:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t ns: memory pipe %h, expected %h", $time, got, exp);
    end
  endtask

  // Results settle one step after the edge that produced them
  always @(posedge clk) begin
    #1;
    if (read_q.size() > 0) cmp_read(read_q.pop_front(), rd_data, rd_valid);
    // An answer nobody asked for is forced to mismatch
    else if (rd_valid !== 1'b0 || rd_data !== '0)
      cmp_read(64'h0000_0000_0000_0000, rd_data, ~rd_valid);
    if (mem_q.size() > 0) cmp_mem(mem_q.pop_front(), {access_violation, paddr_low_out,
      shift_amount_out, wide_address_select, big_endian_mode});
  end

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  task automatic step(input ecv_pkg::ecv_ipr_req_s r, input ecv_pkg::ecv_fault_s f,
                      input ecv_pkg::ecv_mem_s m);
    @(negedge clk);
    ipr_req = r;
    fault = f;
    mem = m;
  endtask

  task automatic rq(input logic w, input logic r, input logic c, input logic [7:0] i,
                    input logic [63:0] d);
    step({w, r, c, i, d}, '0, '0);
  endtask

  task automatic idle(input int n);
    repeat (n) step('0, '0, '0);
  endtask

  task automatic mm(input logic [1:0] sz, input logic [63:0] va, input logic [5:0] ops);
    step('0, '0, {1'b1, va, sz, ops});
  endtask

  task automatic stop_test();
    if (read_q.size() + mem_q.size() != 0) failures++;
    if (failures == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Bounds the whole run against a hang
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    {ipr_req, fault, mem} = '0;
    reset_n = 1'b0;
    failures = 0;
    checked = 0;
    lfsr = 32'hdb59_8ee4;
    idx_list = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'h2b, 8'h2c, 8'h55};
    va_tab = '{64'h0000_0000_0000_0000, 64'hffff_fc00_0000_0000, 64'h0000_0400_0000_0000,
               64'h0000_8000_0000_0000, 64'hffff_8000_0000_0000};
    repeat (16) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    mm(2'h0, va_tab[2], 6'h00);
    // Reset view of every index, then writes where writes must not land
    foreach (idx_list[k]) rq(1'b0, 1'b1, 1'b0, idx_list[k], '0);
    foreach (idx_list[k]) begin
      rnd64(v);
      if (k == 2 || k == 3 || k > 4) rq(1'b1, 1'b1, 1'b0, idx_list[k], v);
      rq(1'b0, 1'b1, 1'b0, idx_list[k], '0);
    end
    // Counter load, run, upper-half write with priority read alongside
    rnd64(v);
    rq(1'b1, 1'b0, 1'b0, 8'hc1, {v[63:33], 1'b1, 32'h1234_567f});
    rq(1'b0, 1'b0, 1'b1, 8'h00, '0);
    idle(5);
    rnd64(v);
    rq(1'b1, 1'b0, 1'b1, 8'hc0, v);
    rq(1'b0, 1'b1, 1'b1, 8'hc2, '0);
    rq(1'b1, 1'b0, 1'b0, 8'hc1, 64'h0000_0000_0000_00a5);
    idle(3);
    rq(1'b0, 1'b1, 1'b0, 8'hc0, '0);
    rq(1'b1, 1'b0, 1'b0, 8'hc1, 64'h0000_0001_ffff_fffb);
    idle(20);
    rq(1'b0, 1'b0, 1'b1, 8'h00, '0);
    // Fault capture, blocked by a page entry load
    rnd64(v);
    step('0, {3'b100, v}, '0);
    rq(1'b0, 1'b1, 1'b0, 8'hc2, '0);
    rnd64(v);
    step('0, {3'b010, v}, '0);
    rnd64(v);
    step('0, {3'b111, v}, '0);
    rq(1'b0, 1'b1, 1'b0, 8'hc2, '0);
    // Entry view in narrow, wide and compact layouts
    for (int m = 0; m < 3; m++) begin
      rnd64(v);
      rq(1'b1, 1'b0, 1'b0, 8'hc4, {v[63:3], m == 2, m == 1, 1'b0});
      rq(1'b0, 1'b1, 1'b0, 8'hc3, '0);
    end
    // Every width and endian mode against every access size
    for (int m = 0; m < 4; m++) begin
      rnd64(v);
      rq(1'b1, 1'b0, 1'b0, 8'hc4, {v[63:3], 1'b0, m[1], m[0]});
      for (int k = 0; k < 8; k++) begin
        rnd64(v);
        mm(k[1:0], (k < 5) ? va_tab[k] : v, v[5:0]);
      end
    end
    // Random mix of all request kinds
    repeat (40) begin
      rnd64(v);
      rq(v[0], v[1], v[2], idx_list[v[5:3]], v);
    end
    // Second reset in mid-run restores the reset state
    idle(2);
    reset_n = 1'b0;
    idle(2);
    reset_n = 1'b1;
    rq(1'b0, 1'b1, 1'b0, 8'hc0, '0);
    rq(1'b0, 1'b1, 1'b0, 8'hc2, '0);
    mm(2'h0, va_tab[2], 6'h2a);
    idle(4);
    stop_test();
  end

endmodule

`default_nettype wire

// ### logic/ecv_ebox_regs.sv
// Purpose: Cycle counter, fault address capture and address control
//          registers of the integer execution box.
// Assumes: Requests are synchronous to clk; at most one read or write
//          and one fault report per cycle.
// Notes:   Reads answer one cycle after the request from a register.
`default_nettype none

module ecv_ebox_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Privileged register access
  input wire ecv_pkg::ecv_ipr_req_s ipr_req,
  output logic [63:0] rd_data,
  output logic rd_valid,
  // Translation miss and fault reports
  input wire ecv_pkg::ecv_fault_s fault,
  // Memory pipe and byte-op operands
  input wire ecv_pkg::ecv_mem_s mem,
  output logic access_violation,
  output logic [2:0] paddr_low_out,
  output logic [2:0] shift_amount_out,
  // Mode bits seen by other units
  output logic wide_address_select,
  output logic big_endian_mode
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] count_lo;
  logic [31:0] count_hi;
  logic count_enable_bit;
  logic [63:0] fault_virtual_address;
  logic [33:0] page_table_base;
  logic compact_format_select;
  logic wide_bit;
  logic big_endian_bit;

  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  wire logic wr_cc = ipr_req.wr && ipr_req.index == ecv_pkg::ECV_IDX_CYCLE_COUNT;
  wire logic wr_ctl = ipr_req.wr && ipr_req.index == ecv_pkg::ECV_IDX_COUNT_CTL;
  wire logic wr_vactl = ipr_req.wr && ipr_req.index == ecv_pkg::ECV_IDX_ADDR_CTL;
  wire logic rd_any = ipr_req.rd || ipr_req.read_cycle_count_op;

  // Plain reads by index; the count instruction outranks them
  wire logic rd_plain = ipr_req.rd && !ipr_req.read_cycle_count_op;
  wire logic rd_count_idx = rd_plain && ipr_req.index == ecv_pkg::ECV_IDX_CYCLE_COUNT;
  wire logic rd_fault_idx = rd_plain && ipr_req.index == ecv_pkg::ECV_IDX_FAULT_VA;
  wire logic rd_view_idx = rd_plain && ipr_req.index == ecv_pkg::ECV_IDX_PTE_VIEW;

  // Capture condition: miss or fault, but not on a page entry load
  wire logic capture = (fault.dtb_miss || fault.dstream_fault) &&
                       !fault.page_entry_load;

  // ----------------------------------------
  // Counter next values
  // ----------------------------------------
  // Lower half wraps in 32 bits; the carry is dropped on purpose
  wire logic [31:0] count_inc = count_lo + 32'h0000_0001;

  // Control write beats the increment in the same cycle
  wire logic [31:0] next_count_lo =
    wr_ctl ? {ipr_req.wdata[31:4], ecv_pkg::ECV_LOW_CLEAR} :
    count_enable_bit ? count_inc : count_lo;

  // Upper half is only touched by a direct counter write
  wire logic [31:0] next_count_hi =
    wr_cc ? ipr_req.wdata[63:32] : count_hi;

  wire logic [63:0] cycle_count_register = {count_hi, count_lo};

  // ----------------------------------------
  // Formatted page table entry view
  // ----------------------------------------
  // Narrow, wide and compact layouts of the entry address
  wire logic [63:0] view_narrow =
    {page_table_base[33:3], fault_virtual_address[42:13], 3'h0};
  wire logic [63:0] view_wide =
    {page_table_base[33:8], fault_virtual_address[47:13], 3'h0};
  wire logic [63:0] view_compact =
    {page_table_base[33:3], 11'h000, fault_virtual_address[31:13], 3'h0};
  wire logic [63:0] pte_address_view =
    compact_format_select ? view_compact :
    wide_bit ? view_wide : view_narrow;

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  // Write-only and unmapped indices read as zero
  wire logic [63:0] next_rd_data =
    ipr_req.read_cycle_count_op ? cycle_count_register :
    !ipr_req.rd ? ecv_pkg::ECV_RESET_WORD :
    ipr_req.index == ecv_pkg::ECV_IDX_CYCLE_COUNT ? cycle_count_register :
    ipr_req.index == ecv_pkg::ECV_IDX_FAULT_VA ? fault_virtual_address :
    ipr_req.index == ecv_pkg::ECV_IDX_PTE_VIEW ? pte_address_view :
    ecv_pkg::ECV_RESET_WORD;

  // ----------------------------------------
  // Cycle counter registers
  // ----------------------------------------
  // Counter halves and enable
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_lo <= ecv_pkg::ECV_RESET_WORD[31:0];
      count_hi <= ecv_pkg::ECV_RESET_WORD[63:32];
      count_enable_bit <= 1'b0;
    end else begin
      count_lo <= next_count_lo;
      count_hi <= next_count_hi;
      if (wr_ctl) begin
        count_enable_bit <= ipr_req.wdata[ecv_pkg::ECV_COUNT_ENABLE_BIT];
      end
    end
  end

  // ----------------------------------------
  // Fault address capture
  // ----------------------------------------
  // Read-only to software; only hardware events load it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_virtual_address <= ecv_pkg::ECV_RESET_WORD;
    end else if (capture) begin
      fault_virtual_address <= fault.vaddr;
    end
  end

  // ----------------------------------------
  // Address format control
  // ----------------------------------------
  // Reserved bits 29:3 are never stored, so writes there do nothing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      page_table_base <= ecv_pkg::ECV_BASE_RESET;
      compact_format_select <= 1'b0;
      wide_bit <= 1'b0;
      big_endian_bit <= 1'b0;
    end else if (wr_vactl) begin
      page_table_base <= ipr_req.wdata[63:ecv_pkg::ECV_BASE_LSB];
      compact_format_select <= ipr_req.wdata[ecv_pkg::ECV_COMPACT_BIT];
      wide_bit <= ipr_req.wdata[ecv_pkg::ECV_WIDE_BIT];
      big_endian_bit <= ipr_req.wdata[ecv_pkg::ECV_BIG_ENDIAN_BIT];
    end
  end

  // Mode outputs follow the stored bits with one register stage
  wire logic next_wide = wide_bit;
  wire logic next_big_endian = big_endian_bit;

  // ----------------------------------------
  // Read port and mode outputs
  // ----------------------------------------
  // Registered answer so rd_data never glitches with the index
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data <= ecv_pkg::ECV_RESET_WORD;
      rd_valid <= 1'b0;
      wide_address_select <= 1'b0;
      big_endian_mode <= 1'b0;
    end else begin
      rd_data <= next_rd_data;
      rd_valid <= rd_any;
      wide_address_select <= next_wide;
      big_endian_mode <= next_big_endian;
    end
  end

  // ----------------------------------------
  // Memory pipe helpers
  // ----------------------------------------
  // Checker uses the live mode bit so a write takes effect next access
  ecv_sign_extend_check u_sign_extend_check (
    .clk(clk),
    .reset_n(reset_n),
    .valid(mem.valid),
    .vaddr(mem.vaddr),
    .wide_address_select(wide_bit),
    .access_violation(access_violation)
  );

  ecv_endian_swizzle u_endian_swizzle (
    .clk(clk),
    .reset_n(reset_n),
    .big_endian(big_endian_bit),
    .size(mem.size),
    .paddr_low(mem.paddr_low),
    .shift_amount(mem.shift_amount),
    .paddr_low_out(paddr_low_out),
    .shift_amount_out(shift_amount_out)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Steps of a control write followed by free running
  sequence s_ctl_write;
    wr_ctl && ipr_req.wdata[ecv_pkg::ECV_COUNT_ENABLE_BIT];
  endsequence

  sequence s_quiet_two;
    !wr_ctl [*2];
  endsequence

  a_count_advance: assert property (
    count_enable_bit && !wr_ctl |=> count_lo == $past(count_lo) + 32'h0000_0001)
    else $error("enabled count did not advance");

  a_count_hold: assert property (
    !count_enable_bit && !wr_ctl |=> $stable(count_lo))
    else $error("disabled count moved");

  a_upper_storage: assert property (
    !wr_cc |=> $stable(count_hi))
    else $error("upper half changed without a write");

  a_upper_only_write: assert property (
    wr_cc && !wr_ctl |=> count_hi == $past(ipr_req.wdata[63:32]) &&
      count_lo == $past(count_lo) + {31'h0000_0000, $past(count_enable_bit)})
    else $error("counter write disturbed lower half");

  a_full_read: assert property (
    ipr_req.read_cycle_count_op |=> rd_valid && rd_data == $past({count_hi, count_lo}))
    else $error("cycle count read incomplete");

  a_ctl_load: assert property (
    wr_ctl |=> count_lo == {$past(ipr_req.wdata[31:4]), 4'h0})
    else $error("control write load wrong");

  // Load lands at the write edge; at the second quiet edge one count has passed
  a_ctl_run: assert property (
    s_ctl_write ##1 s_quiet_two |-> count_lo[3:0] == 4'h1)
    else $error("count did not restart from cleared low bits");

  a_fault_capture: assert property (
    capture |=> fault_virtual_address == $past(fault.vaddr))
    else $error("fault address not captured");

  a_pte_load_keep: assert property (
    fault.page_entry_load |=> $stable(fault_virtual_address))
    else $error("page entry load overwrote fault address");

  a_wide_write: assert property (
    wr_vactl |=> ##1 wide_address_select == $past(ipr_req.wdata[1], 2))
    else $error("wide select not taken from bit 1");

  a_write_only_zero: assert property (
    ipr_req.rd && !ipr_req.read_cycle_count_op &&
      (ipr_req.index == ecv_pkg::ECV_IDX_COUNT_CTL ||
       ipr_req.index == ecv_pkg::ECV_IDX_ADDR_CTL) |=> rd_data == 64'h0000_0000_0000_0000)
    else $error("write-only register read nonzero");

  a_view_narrow: assert property (
    ipr_req.rd && !ipr_req.read_cycle_count_op &&
      ipr_req.index == ecv_pkg::ECV_IDX_PTE_VIEW && !wide_bit && !compact_format_select
      |=> rd_data[32:3] == $past(fault_virtual_address[42:13]))
    else $error("entry view lost fault address");

  a_wrap_no_carry: assert property (
    count_lo == 32'hffff_ffff && count_enable_bit && !wr_ctl && !wr_cc
      |=> count_lo == 32'h0000_0000 && $stable(count_hi))
    else $error("wrap carried into upper half");

  // ----------------------------------------
  // Read answers, captured address and counter control
  // ----------------------------------------
  // A cycle without a read must leave the answer port quiet
  a_idle_read: assert property (
    !rd_any |=> !rd_valid && rd_data == 64'h0000_0000_0000_0000)
    else $error("answer without a read");

  a_count_read: assert property (
    rd_count_idx |=> rd_valid && rd_data == $past(cycle_count_register))
    else $error("indexed counter read wrong");

  a_fault_read: assert property (
    rd_fault_idx |=> rd_valid && rd_data == $past(fault_virtual_address))
    else $error("fault address read wrong");

  // Software can never write the captured address; only a capture moves it
  a_fault_hold: assert property (
    !capture |=> $stable(fault_virtual_address))
    else $error("fault address moved without capture");

  // Enable follows bit 32 of every control write, whatever the count bits
  a_enable_load: assert property (
    wr_ctl |=> count_enable_bit == $past(ipr_req.wdata[ecv_pkg::ECV_COUNT_ENABLE_BIT]))
    else $error("count enable not taken from bit 32");

  a_ctl_priority: assert property (
    wr_ctl && count_enable_bit |=> count_lo[3:0] == 4'h0)
    else $error("increment beat the control write");

  // ----------------------------------------
  // Address control and entry view
  // ----------------------------------------
  // Steps of an address-control write reaching the mode pins
  sequence s_mode_write;
    wr_vactl ##1 !wr_vactl;
  endsequence

  a_base_load: assert property (
    wr_vactl |=> page_table_base == $past(ipr_req.wdata[63:30]))
    else $error("table base not taken from bits 63:30");

  a_mode_load: assert property (
    wr_vactl |=> compact_format_select == $past(ipr_req.wdata[2]) &&
      wide_bit == $past(ipr_req.wdata[1]) && big_endian_bit == $past(ipr_req.wdata[0]))
    else $error("mode bits not taken from bits 2:0");

  a_endian_pin: assert property (
    s_mode_write |=> big_endian_mode == $past(ipr_req.wdata[0], 2))
    else $error("endian pin not taken from bit 0");

  a_wide_pin: assert property (
    1'b1 |=> wide_address_select == $past(wide_bit))
    else $error("wide pin does not follow stored bit");

  // Narrow and compact layouts share the base field at the top
  a_view_base: assert property (
    rd_view_idx && !(wide_bit && !compact_format_select)
      |=> rd_data[63:33] == $past(page_table_base[33:3]))
    else $error("entry view base field wrong");

  a_view_wide: assert property (
    rd_view_idx && wide_bit && !compact_format_select
      |=> rd_data[63:38] == $past(page_table_base[33:8]) &&
      rd_data[37:3] == $past(fault_virtual_address[47:13]))
    else $error("wide entry view wrong");

  // Compact layout keeps only the low 32-bit page number
  a_view_compact: assert property (
    rd_view_idx && compact_format_select |=> rd_data[32:22] == 11'h000 &&
      rd_data[21:3] == $past(fault_virtual_address[31:13]))
    else $error("compact entry view wrong");

  a_view_align: assert property (
    rd_view_idx |=> rd_data[2:0] == 3'h0)
    else $error("entry view not quadword aligned");

endmodule

`default_nettype wire

// ### logic/ecv_endian_swizzle.sv
// Purpose: Big-endian inversion of shift amount and low address bits.
// Assumes: Size code accompanies each data-stream address.
// Notes:   Quadword references keep their low address bits; the shift amount is still inverted.
`default_nettype none

module ecv_endian_swizzle (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Mode and operands
  input wire logic big_endian,
  input wire ecv_pkg::ecv_size_e size,
  input wire logic [2:0] paddr_low,
  input wire logic [2:0] shift_amount,
  // Results
  output logic [2:0] paddr_low_out,
  output logic [2:0] shift_amount_out
);

  // ----------------------------------------
  // Inversion masks
  // ----------------------------------------
  wire logic [2:0] size_mask =
    (size == ecv_pkg::ECV_SIZE_BYTE) ? 3'h7 :
    (size == ecv_pkg::ECV_SIZE_WORD) ? 3'h6 :
    (size == ecv_pkg::ECV_SIZE_LONG) ? 3'h4 : 3'h0;
  wire logic [2:0] addr_mask = big_endian ? size_mask : 3'h0;
  wire logic [2:0] shift_mask = {3{big_endian}};

  // Registered results
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      paddr_low_out <= 3'h0;
      shift_amount_out <= 3'h0;
    end else begin
      paddr_low_out <= paddr_low ^ addr_mask;
      shift_amount_out <= shift_amount ^ shift_mask;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_shift_invert: assert property (
    ##1 shift_amount_out == ($past(big_endian) ? ~$past(shift_amount) : $past(shift_amount)))
    else $error("shift amount inversion wrong");

  a_byte_invert: assert property (
    big_endian && size == ecv_pkg::ECV_SIZE_BYTE |=> paddr_low_out == ~$past(paddr_low))
    else $error("byte address inversion wrong");

endmodule

`default_nettype wire

// ### logic/ecv_pkg.sv
// Purpose: Constants and carriers for the execution-box counter and
//          address-control register logic.
// Assumes: Privileged register accesses arrive as one request per cycle.
`default_nettype none

package ecv_pkg;

  // ----------------------------------------
  // Register indices
  // ----------------------------------------
  localparam logic [7:0] ECV_IDX_CACHE_DATA = 8'h2b;
  localparam logic [7:0] ECV_IDX_CACHE_SHIFT = 8'h2c;
  localparam logic [7:0] ECV_IDX_CYCLE_COUNT = 8'hc0;
  localparam logic [7:0] ECV_IDX_COUNT_CTL = 8'hc1;
  localparam logic [7:0] ECV_IDX_FAULT_VA = 8'hc2;
  localparam logic [7:0] ECV_IDX_PTE_VIEW = 8'hc3;
  localparam logic [7:0] ECV_IDX_ADDR_CTL = 8'hc4;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int ECV_COUNT_ENABLE_BIT = 32;
  localparam int ECV_BASE_LSB = 30;
  localparam int ECV_COMPACT_BIT = 2;
  localparam int ECV_WIDE_BIT = 1;
  localparam int ECV_BIG_ENDIAN_BIT = 0;
  localparam int ECV_WIDE_SIGN_BIT = 47;
  localparam int ECV_NARROW_SIGN_BIT = 42;
  localparam logic [63:0] ECV_RESET_WORD = 64'h0000_0000_0000_0000;
  localparam logic [33:0] ECV_BASE_RESET = 34'h0_0000_0000;
  localparam logic [3:0] ECV_LOW_CLEAR = 4'h0;

  // ----------------------------------------
  // Access sizes of data-stream references
  // ----------------------------------------
  typedef enum logic [1:0] {
    ECV_SIZE_BYTE = 2'h0,
    ECV_SIZE_WORD = 2'h1,
    ECV_SIZE_LONG = 2'h2,
    ECV_SIZE_QUAD = 2'h3
  } ecv_size_e;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic read_cycle_count_op;
    logic [7:0] index;
    logic [63:0] wdata;
  } ecv_ipr_req_s;

  typedef struct packed {
    logic dtb_miss;
    logic dstream_fault;
    logic page_entry_load;
    logic [63:0] vaddr;
  } ecv_fault_s;

  typedef struct packed {
    logic valid;
    logic [63:0] vaddr;
    ecv_size_e size;
    logic [2:0] paddr_low;
    logic [2:0] shift_amount;
  } ecv_mem_s;

  // Address outside its sign-extended range for the chosen width
  function automatic logic ecv_sign_extend_bad(input logic [63:0] va, input logic wide);
    logic [63:0] ext;
    ext = wide ? {{16{va[ECV_WIDE_SIGN_BIT]}}, va[47:0]}
               : {{21{va[ECV_NARROW_SIGN_BIT]}}, va[42:0]};
    return ext != va;
  endfunction

endpackage

`default_nettype wire

// ### logic/ecv_sign_extend_check.sv
// Purpose: Memory-pipe virtual address sign-extension checker.
// Assumes: One address offered per valid cycle.
// Notes:   Result is registered; one cycle after the address.
`default_nettype none

module ecv_sign_extend_check (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Address under test
  input wire logic valid,
  input wire logic [63:0] vaddr,
  input wire logic wide_address_select,
  // Result
  output logic access_violation
);

  // ----------------------------------------
  // Check
  // ----------------------------------------
  wire logic bad = valid && ecv_pkg::ecv_sign_extend_bad(vaddr, wide_address_select);

  // Registered flag, one cycle per offending access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      access_violation <= 1'b0;
    end else begin
      access_violation <= bad;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_wide_sign_extend_flag: assert property (
    valid && wide_address_select |=>
      access_violation == ($past(vaddr[63:47]) != {17{$past(vaddr[47])}}))
    else $error("wide sign check wrong");

  a_narrow_sign_extend_flag: assert property (
    valid && !wide_address_select |=>
      access_violation == ($past(vaddr[63:42]) != {22{$past(vaddr[42])}}))
    else $error("narrow sign check wrong");

endmodule

`default_nettype wire
